// ---- hw/guard_flag.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "positioner_map.svh"

// One write-guard flag: 8 bits wide, holds 0 or 1 only
module guard_flag (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    output logic value_ok,
    output logic is_open,
    output logic [7:0] flag_r
);

    // Only 0 and 1 are legal; anything else is refused
    assign value_ok = (wdata <= `GUARD_MAX);
    assign is_open = (flag_r != `RST_GUARD);

    // Flag storage, closed after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= `RST_GUARD;
        end else if (wr_en && value_ok) begin
            flag_r <= wdata[7:0];
        end
    end

endmodule

`default_nettype wire

// ---- hw/limit_check.sv ----
`timescale 1ns/10ps
`default_nettype none

// Signed inclusive range check shared by several parameters
module limit_check (
    input wire logic [31:0] value,
    input wire logic [31:0] lo,
    input wire logic [31:0] hi,
    output logic in_range
);

    // Compare as two's complement so negative values fail a positive floor
    assign in_range = ($signed(value) >= $signed(lo)) &&
                      ($signed(value) <= $signed(hi));

endmodule

`default_nettype wire

// ---- hw/positioner_map.svh ----
`ifndef POSITIONER_MAP_SVH
`define POSITIONER_MAP_SVH

// Parameter indices of the run command and positioning-values groups
`define IDX_CMD_GUARD 8'h6d
`define IDX_CMD_WORD 8'h6e
`define IDX_TGT_GUARD 8'h6f
`define IDX_TARGET 8'h70
`define IDX_ROTATION 8'h73
`define IDX_SCALE_NUM 8'h74
`define IDX_SCALE_DEN 8'h75
`define IDX_REF_GUARD 8'h76
`define IDX_REF_OFFSET 8'h77

// Reset values
`define RST_GUARD 8'h00
`define RST_CMD_WORD 16'h0000
`define RST_TARGET 32'h00000000
`define RST_ROTATION 8'h00
`define RST_SCALE 16'h0190
`define RST_REF_OFFSET 32'h00000000

// Command word bit positions
`define CMD_BIT_JOG_UP 0
`define CMD_BIT_JOG_DOWN 1
`define CMD_BIT_TAKE_TARGET 2
`define CMD_BIT_RELEASE 4
`define CMD_BIT_NO_LOOP 6
`define CMD_PSET_LSB 8
`define CMD_PSET_MSB 9
`define CMD_BIT_TOGGLE 13
`define CMD_BIT_ERR_ACK 14
`define CMD_DEFINED_MASK 16'h6357

// Value limits
`define GUARD_MAX 32'h00000001
`define ROTATION_MAX 32'h00000001
`define SCALE_MIN 32'h00000001
`define SCALE_MAX 32'h00002710
`define POS_MIN 32'h80000001
`define POS_MAX 32'h7fffffff

`endif

// ---- hw/positioner_pkg.sv ----
package positioner_pkg;

    // What a parameter write does to its target register
    typedef enum logic [1:0] {
        wr_store,
        wr_suppress,
        wr_refuse
    } wr_outcome_t;

    typedef logic [7:0] param_index_t;

    // Shifts a raw position by the referencing offset; wraps on overflow
    function automatic logic [31:0] add_offset(
        input logic [31:0] pos,
        input logic [31:0] ofs
    );
        return pos + ofs;
    endfunction

endpackage

// ---- hw/positioner_run_command_params.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "positioner_map.svh"

module positioner_run_command_params #(
    parameter logic has_pset_option = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    // Indexed parameter service
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_index,
    input wire logic [31:0] req_wdata,
    output logic resp_valid,
    output logic resp_ok,
    output logic [31:0] resp_rdata,
    // Cyclic process data
    input wire logic pd_target_valid,
    input wire logic [31:0] pd_target,
    // Drive state
    input wire logic axis_still,
    input wire logic [31:0] actual_raw,
    // Controls toward the motion core
    output logic jog_up,
    output logic jog_down,
    output logic drive_enable,
    output logic no_loop,
    output logic [1:0] param_set,
    output logic toggle_bit,
    output logic error_ack,
    output logic rotation_ccw,
    output logic [15:0] scale_num,
    output logic [15:0] scale_den,
    output logic [31:0] target_abs,
    output logic [31:0] actual_pos
);

    // Stored parameters
    logic [15:0] cmd_word_r, scale_num_r, scale_den_r;
    logic [31:0] target_r, ref_offset_r;
    logic [7:0] rotation_r, cmd_guard_r, tgt_guard_r, ref_guard_r;

    // Guard status
    logic cmd_guard_ok, tgt_guard_ok, ref_guard_ok;
    logic cmd_open, tgt_open, ref_open;

    // Range checks
    logic wr_pos_ok, pd_pos_ok, scale_ok, small_ok;

    // Decoded access
    logic wr_req, mapped, pd_take;
    positioner_pkg::wr_outcome_t outcome;
    logic [31:0] rd_value;

    assign wr_req = req_valid && req_write;

    // Guard flags, written straight from the service port
    guard_flag u_cmd_guard (
        .clk(clk), .rstn(rstn), .wdata(req_wdata),
        .wr_en(wr_req && (req_index == `IDX_CMD_GUARD)),
        .value_ok(cmd_guard_ok), .is_open(cmd_open), .flag_r(cmd_guard_r)
    );

    guard_flag u_tgt_guard (
        .clk(clk), .rstn(rstn), .wdata(req_wdata),
        .wr_en(wr_req && (req_index == `IDX_TGT_GUARD)),
        .value_ok(tgt_guard_ok), .is_open(tgt_open), .flag_r(tgt_guard_r)
    );

    guard_flag u_ref_guard (
        .clk(clk), .rstn(rstn), .wdata(req_wdata),
        .wr_en(wr_req && (req_index == `IDX_REF_GUARD)),
        .value_ok(ref_guard_ok), .is_open(ref_open), .flag_r(ref_guard_r)
    );

    limit_check u_wr_pos_chk (
        .value(req_wdata), .lo(`POS_MIN), .hi(`POS_MAX),
        .in_range(wr_pos_ok)
    );

    // Process data gets its own check, it may arrive with a service write
    limit_check u_pd_pos_chk (
        .value(pd_target), .lo(`POS_MIN), .hi(`POS_MAX),
        .in_range(pd_pos_ok)
    );

    limit_check u_scale_chk (
        .value(req_wdata), .lo(`SCALE_MIN), .hi(`SCALE_MAX),
        .in_range(scale_ok)
    );

    // rotation sense is 0 or 1 only
    assign small_ok = (req_wdata <= `ROTATION_MAX);

    // Decide what a write does; guards are looked at before standstill
    always_comb begin
        outcome = positioner_pkg::wr_refuse;
        case (req_index)
            `IDX_CMD_GUARD: begin
                if (cmd_guard_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_CMD_WORD: begin
                // closed guard drops the command write
                if (!cmd_open) begin
                    outcome = positioner_pkg::wr_suppress;
                end else begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_TGT_GUARD: begin
                if (tgt_guard_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_TARGET: begin
                // closed guard drops the service write; process data can still load the target
                if (!tgt_open) begin
                    outcome = positioner_pkg::wr_suppress;
                end else if (wr_pos_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_ROTATION: begin
                if (axis_still && small_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_SCALE_NUM: begin
                if (scale_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_SCALE_DEN: begin
                if (axis_still && scale_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_REF_GUARD: begin
                if (ref_guard_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            `IDX_REF_OFFSET: begin
                // closed guard drops the referencing write
                if (!ref_open) begin
                    outcome = positioner_pkg::wr_suppress;
                end else if (axis_still && wr_pos_ok) begin
                    outcome = positioner_pkg::wr_store;
                end
            end
            default: begin
                outcome = positioner_pkg::wr_refuse;
            end
        endcase
    end

    // Command word; undefined bits are dropped so they read back as zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_word_r <= `RST_CMD_WORD;
        end else if (wr_req && (req_index == `IDX_CMD_WORD) &&
                     (outcome == positioner_pkg::wr_store)) begin
            // reserved bits masked in case the master sets them
            cmd_word_r <= req_wdata[15:0] & `CMD_DEFINED_MASK;
        end
    end

    // process-data target only with transfer bit set
    assign pd_take = pd_target_valid && pd_pos_ok &&
                     cmd_word_r[`CMD_BIT_TAKE_TARGET];

    // Target position; a service write wins over process data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            target_r <= `RST_TARGET;
        end else if (wr_req && (req_index == `IDX_TARGET) &&
                     (outcome == positioner_pkg::wr_store)) begin
            // signed 32-bit target, not backed up
            target_r <= req_wdata;
        end else if (pd_take) begin
            target_r <= pd_target;
        end
    end

    // Positioning values
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rotation_r <= `RST_ROTATION;
            scale_num_r <= `RST_SCALE;
            scale_den_r <= `RST_SCALE;
            ref_offset_r <= `RST_REF_OFFSET;
        end else if (wr_req && (outcome == positioner_pkg::wr_store)) begin
            case (req_index)
                `IDX_ROTATION: rotation_r <= req_wdata[7:0];
                // scaling factors within 1 to 10000
                `IDX_SCALE_NUM: scale_num_r <= req_wdata[15:0];
                `IDX_SCALE_DEN: scale_den_r <= req_wdata[15:0];
                `IDX_REF_OFFSET: ref_offset_r <= req_wdata;
                default: begin
                end
            endcase
        end
    end

    // Read-back of every mapped parameter
    always_comb begin
        rd_value = 32'h00000000;
        mapped = 1'b1;
        case (req_index)
            `IDX_CMD_GUARD: rd_value = {24'h000000, cmd_guard_r};
            `IDX_CMD_WORD: rd_value = {16'h0000, cmd_word_r};
            `IDX_TGT_GUARD: rd_value = {24'h000000, tgt_guard_r};
            `IDX_TARGET: rd_value = target_r;
            `IDX_ROTATION: rd_value = {24'h000000, rotation_r};
            `IDX_SCALE_NUM: rd_value = {16'h0000, scale_num_r};
            `IDX_SCALE_DEN: rd_value = {16'h0000, scale_den_r};
            `IDX_REF_GUARD: rd_value = {24'h000000, ref_guard_r};
            `IDX_REF_OFFSET: rd_value = ref_offset_r;
            default: mapped = 1'b0;
        endcase
    end

    // Answer one cycle after each request; a suppressed write still
    // completes, so the master cannot tell it from a stored one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resp_valid <= 1'b0;
            resp_ok <= 1'b0;
            resp_rdata <= 32'h00000000;
        end else begin
            resp_valid <= req_valid;
            if (!req_valid) begin
                resp_ok <= 1'b0;
                resp_rdata <= 32'h00000000;
            end else if (req_write) begin
                resp_ok <= (outcome != positioner_pkg::wr_refuse);
                resp_rdata <= 32'h00000000;
            end else begin
                resp_ok <= mapped;
                resp_rdata <= rd_value;
            end
        end
    end

    // Motion controls from the command word
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_enable <= 1'b0;
            jog_up <= 1'b0;
            jog_down <= 1'b0;
            no_loop <= 1'b0;
        end else begin
            drive_enable <= cmd_word_r[`CMD_BIT_RELEASE];
            // opposing jog requests cancel rather than fight
            jog_up <= cmd_word_r[`CMD_BIT_RELEASE] &&
                      cmd_word_r[`CMD_BIT_JOG_UP] &&
                      !cmd_word_r[`CMD_BIT_JOG_DOWN];
            jog_down <= cmd_word_r[`CMD_BIT_RELEASE] &&
                        cmd_word_r[`CMD_BIT_JOG_DOWN] &&
                        !cmd_word_r[`CMD_BIT_JOG_UP];
            no_loop <= cmd_word_r[`CMD_BIT_NO_LOOP];
        end
    end

    // Handshake and set selection bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            param_set <= 2'b00;
            toggle_bit <= 1'b0;
            error_ack <= 1'b0;
        end else begin
            // set 0 stays active without the changeover option
            param_set <= has_pset_option ?
                cmd_word_r[`CMD_PSET_MSB:`CMD_PSET_LSB] : 2'b00;
            toggle_bit <= cmd_word_r[`CMD_BIT_TOGGLE];
            error_ack <= cmd_word_r[`CMD_BIT_ERR_ACK];
        end
    end

    // Scaling and direction toward the position core
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rotation_ccw <= 1'b0;
            scale_num <= `RST_SCALE;
            scale_den <= `RST_SCALE;
        end else begin
            rotation_ccw <= rotation_r[0];
            // denominator carries pitch over resolution at num 400
            scale_num <= scale_num_r;
            scale_den <= scale_den_r;
        end
    end

    // Offset-corrected positions, registered to cut the adder path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            target_abs <= 32'h00000000;
            actual_pos <= 32'h00000000;
        end else begin
            // referencing offset on target and actual values
            target_abs <= positioner_pkg::add_offset(target_r, ref_offset_r);
            actual_pos <= positioner_pkg::add_offset(actual_raw, ref_offset_r);
        end
    end

endmodule

`default_nettype wire

// ---- sim/param_master.sv ----
`timescale 1ns/10ps
`default_nettype none

// Service master: one request at a time, answer taken one cycle later
module param_master (
    input wire logic clk,
    output var logic req_valid,
    output var logic req_write,
    output var logic [7:0] req_index,
    output var logic [31:0] req_wdata,
    input wire logic resp_valid,
    input wire logic resp_ok,
    input wire logic [31:0] resp_rdata
);
    // Idle request lines from time zero
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_index = 8'h00;
        req_wdata = 32'h00000000;
    end

    // One request pulse, answer sampled in the following cycle
    task automatic xfer(input logic w, input logic [7:0] i,
                        input logic [31:0] d, output logic ok,
                        output logic [31:0] rd);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = w;
        req_index = i;
        req_wdata = (w && i == 8'h6e) ? (d & 32'h00006357) : d;
        @(posedge clk);
        #1;
        // Released data toggles so stale values are never taken as fresh
        req_valid = 1'b0;
        req_wdata = ~req_wdata;
        ok = resp_valid ? resp_ok : 1'bx;
        rd = resp_rdata;
    endtask
endmodule

`default_nettype wire

// ---- sim/positioner_run_command_params_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

// Port-level checks of the parameter service and motion controls
module positioner_run_command_params_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_index,
    input wire logic [31:0] req_wdata,
    input wire logic axis_still,
    input wire logic resp_valid,
    input wire logic resp_ok,
    input wire logic [31:0] resp_rdata,
    input wire logic jog_up,
    input wire logic jog_down,
    input wire logic drive_enable,
    input wire logic [15:0] scale_num
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_resp_follows: assert property (req_valid |=> resp_valid)
        else $error("request without answer");
    chk_resp_single: assert property (!req_valid |=> !resp_valid)
        else $error("answer without request");
    chk_idle_clean: assert property
        (!resp_valid |-> !resp_ok && resp_rdata == 32'h00000000)
        else $error("answer fields active while idle");
    chk_release_gate: assert property
        (!drive_enable |-> !jog_up && !jog_down)
        else $error("motion without release");
    chk_jog_excl: assert property (!(jog_up && jog_down))
        else $error("both run directions at once");
    chk_rot_moving: assert property (req_valid && req_write &&
        req_index == 8'h73 && !axis_still |=> !resp_ok)
        else $error("rotation accepted while moving");
    chk_den_moving: assert property (req_valid && req_write &&
        req_index == 8'h75 && !axis_still |=> !resp_ok)
        else $error("denominator accepted while moving");
    chk_num_range: assert property (req_valid && req_write &&
        req_index == 8'h74 && (req_wdata == 32'h00000000 ||
        req_wdata > 32'h00002710) |=> !resp_ok ##1 $stable(scale_num))
        else $error("numerator out of range taken");
    chk_unmapped: assert property (req_valid &&
        req_index inside {8'h71, 8'h72, 8'h78} |=>
        resp_valid && !resp_ok && resp_rdata == 32'h00000000)
        else $error("unmapped index answered");
endmodule

bind positioner_run_command_params positioner_run_command_params_asserts
    i_chk (.clk, .rstn, .req_valid, .req_write, .req_index, .req_wdata,
    .axis_still, .resp_valid, .resp_ok, .resp_rdata, .jog_up, .jog_down,
    .drive_enable, .scale_num);

`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    error_cnt++; $display("wrong value at %0t: got %h exp %h", \
    $time, a, b); end end

module tb_top;
    typedef struct {bit s; int i; logic [31:0] d;} step_t;
    logic clk = 1'b0, rstn = 1'b0, axis_still = 1'b1;
    logic req_valid, req_write, resp_valid, resp_ok, pd_target_valid = 1'b0;
    logic [7:0] req_index;
    logic [31:0] req_wdata, resp_rdata, pd_target = 32'h0;
    logic [31:0] actual_raw = 32'h0, target_abs, actual_pos;
    logic jog_up, jog_down, drive_enable, no_loop, toggle_bit, error_ack;
    logic rotation_ccw;
    logic [1:0] param_set;
    logic [15:0] scale_num, scale_den;
    int error_cnt = 0, total_checks = 0;
    logic [31:0] m [int];
    int ix[9] = '{'h6d, 'h6e, 'h6f, 'h70, 'h73, 'h74, 'h75, 'h76, 'h77};
    step_t steps[19] = '{'{1, 'h6e, 'h13}, '{1, 'h6d, 2}, '{1, 'h6d, 1},
        '{1, 'h70, 'h1234}, '{1, 'h6f, 1}, '{1, 'h70, 'h80000000},
        '{1, 'h70, 'hfffffff0}, '{0, 'h73, 1}, '{1, 'h73, 1},
        '{1, 'h74, 0}, '{1, 'h74, 10001}, '{1, 'h74, 10000},
        '{0, 'h75, 150}, '{1, 'h75, 150}, '{1, 'h77, 5}, '{1, 'h76, 1},
        '{0, 'h77, 5}, '{1, 'h77, 'h100}, '{1, 'h73, 2}};

    // Free-running 25 MHz clock
    always #20 clk = ~clk;

    positioner_run_command_params i_positioner_run_command_params (
        .clk(clk), .rstn(rstn), .req_valid(req_valid),
        .req_write(req_write), .req_index(req_index),
        .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_ok(resp_ok),
        .resp_rdata(resp_rdata), .pd_target_valid(pd_target_valid),
        .pd_target(pd_target), .axis_still(axis_still),
        .actual_raw(actual_raw), .jog_up(jog_up), .jog_down(jog_down),
        .drive_enable(drive_enable), .no_loop(no_loop),
        .param_set(param_set), .toggle_bit(toggle_bit),
        .error_ack(error_ack), .rotation_ccw(rotation_ccw),
        .scale_num(scale_num), .scale_den(scale_den),
        .target_abs(target_abs), .actual_pos(actual_pos));

    param_master i_param_master (.clk(clk), .req_valid(req_valid),
        .req_write(req_write), .req_index(req_index),
        .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_ok(resp_ok),
        .resp_rdata(resp_rdata));

    // Reference write: guard first, then standstill and range
    function automatic logic mwr(int i, logic [31:0] d);
        int g;
        g = (i == 'h6e) ? 'h6d : (i == 'h70) ? 'h6f : (i == 'h77) ? 'h76 : 0;
        if (!m.exists(i)) return 1'b0;
        if (g != 0 && m[g] == 0) return 1'b1;
        if (i == 'h6e) d = d & 'h6357;
        if ((i == 'h6d || i == 'h6f || i == 'h76) && d > 1) return 1'b0;
        if ((i == 'h70 || i == 'h77) && d == 'h80000000) return 1'b0;
        if ((i == 'h73 || i == 'h75 || i == 'h77) && !axis_still) return 1'b0;
        if (i == 'h73 && d > 1) return 1'b0;
        if ((i == 'h74 || i == 'h75) && (d < 1 || d > 10000)) return 1'b0;
        m[i] = d;
        return 1'b1;
    endfunction

    task automatic op(input logic w, input int i, input logic [31:0] d);
        logic ok, eok;
        logic [31:0] rd, erd;
        erd = 32'h0;
        eok = (m.exists(i) != 0);
        if (w) eok = mwr(i, d);
        else if (eok) erd = m[i];
        i_param_master.xfer(w, i[7:0], d, ok, rd);
        `CHK(ok, eok)
        `CHK(rd, erd)
    endtask

    task automatic check_outs;
        logic [31:0] c;
        @(posedge clk);
        #1;
        c = m['h6e];
        `CHK(drive_enable, c[4])
        `CHK(jog_up, c[4] & c[0] & ~c[1])
        `CHK(jog_down, c[4] & c[1] & ~c[0])
        `CHK(no_loop, c[6])
        `CHK(param_set, c[9:8])
        `CHK({error_ack, toggle_bit}, c[14:13])
        `CHK(rotation_ccw, m['h73][0])
        `CHK(scale_num, m['h74][15:0])
        `CHK(scale_den, m['h75][15:0])
        `CHK(target_abs, m['h70] + m['h77])
        `CHK(actual_pos, actual_raw + m['h77])
    endtask

    // Process-data target strobe for one cycle
    task automatic pd_send(input logic [31:0] v);
        @(posedge clk);
        #1;
        pd_target_valid = 1'b1;
        pd_target = v;
        if (m['h6e][2] && v != 'h80000000) m['h70] = v;
        @(posedge clk);
        #1;
        pd_target_valid = 1'b0;
        pd_target = ~v;
        check_outs();
    endtask

    task automatic close_out;
        if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang limit well beyond the whole sequence
    initial begin
        #(40 * 50000);
        error_cnt++;
        close_out();
    end

    // Main sequence
    initial begin
        void'($urandom(46381));
        foreach (ix[k]) m[ix[k]] = 0;
        m['h74] = 400;
        m['h75] = 400;
        actual_raw = $urandom;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        foreach (ix[k]) op(0, ix[k], 0);
        op(0, 'h71, 0);
        foreach (steps[k]) begin
            axis_still = steps[k].s;
            op(1, steps[k].i, steps[k].d);
            axis_still = 1'b1;
            op(0, steps[k].i, 0);
            check_outs();
        end
        pd_send(32'h00000777);
        for (int k = 0; k < 12; k++) begin
            op(1, 'h6e, $urandom);
            check_outs();
        end
        op(1, 'h6e, 'h10);
        pd_send(32'h00000555);
        op(1, 'h6e, 'h14);
        pd_send($urandom);
        op(1, 'h70, $urandom);
        check_outs();
        close_out();
    end
endmodule

`default_nettype wire
